// *** pmc_pkg.sv ***
// Constants and types shared by the power mode controller and its wake timer.
//
// Contract
// - Active mode runs processor and enabled peripherals.
// - Idle gates processor and memory; interrupts wake.
// - Standby keeps only always-on domain; selected wakes.
// - Standby wake resumes processor; retention keeps configuration.
// - I/O pins stay latched throughout standby.
// - Shutdown powers everything off, I/O stays latched.
// - Shutdown wake pin change acts as reset.
// - Reset cause distinguishes pin wake, pin, power-on.
// - Wake latencies 14, 151 and 1015 us.
// - Reset pin always wakes; pin edge and clock limited.
// - Standby brown-out detector duty cycled; trip locks device.
// - 24 MHz crystal doubled to 48 MHz clock.
// - Slow clock may come from internal RC oscillator.
// - Sensor processor runs alone; configured conditions wake.
// - Always-on domain on except in shutdown; the controller also turns it off in held reset.
// - Real-time clock wakes whenever its clock runs.
package pmc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 40;    // System clock rate in MHz.
  localparam int unsigned WAKE_IDLE_US     = 14;    // Wake latency from idle.
  localparam int unsigned WAKE_STBY_US     = 151;   // Wake latency from standby.
  localparam int unsigned WAKE_BOOT_US     = 1015;  // Wake latency from shutdown or reset.
  localparam int unsigned WAKE_IDLE_CYCLES = WAKE_IDLE_US * CLK_MHZ;
  localparam int unsigned WAKE_STBY_CYCLES = WAKE_STBY_US * CLK_MHZ;
  localparam int unsigned WAKE_BOOT_CYCLES = WAKE_BOOT_US * CLK_MHZ;
  localparam int unsigned PD_CYCLES        = 4;     // Power-down sequence length.
  localparam int unsigned RECHARGE_CYCLES  = 4000;  // Standby supply recharge period.
  localparam int unsigned TMR_W            = 16;    // Wake timer width.

  // ----------------------------------------------------------------
  // Clock references
  // ----------------------------------------------------------------
  localparam int unsigned FAST_XTAL_MHZ = 24;  // Crystal reference, used only when fast_xtal_sel_i is set.
  localparam int unsigned FAST_CLK_MHZ  = 48;  // Doubled high-speed clock.

  // ----------------------------------------------------------------
  // Reset cause codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CAUSE_POR    = 2'h0;  // Power-on reset.
  localparam logic [1:0] CAUSE_PIN    = 2'h1;  // Reset pin.
  localparam logic [1:0] CAUSE_SDWAKE = 2'h2;  // Shutdown wake pin.

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_ACTIVE   = 4'h0,
    ST_PD       = 4'h1,
    ST_IDLE     = 4'h2,
    ST_STANDBY  = 4'h3,
    ST_SHUTDOWN = 4'h4,
    ST_HELD     = 4'h5,
    ST_WAKE     = 4'h6,
    ST_LOCKED   = 4'h7
  } pmc_state_e;

endpackage

// *** wake_timer.sv ***
// Down-counter that times the power-down sequence and wake latencies.
`timescale 1ns/1ps
module wake_timer
  import pmc_pkg::*;
#(
  parameter int unsigned WIDTH = TMR_W
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Load and expiry.
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  output logic                  done_o
);

  logic [WIDTH-1:0] cnt_q;  // Remaining cycles.

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A load restarts the count; otherwise it runs down to zero and stops.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= count_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Expiry is a one-cycle pulse on the edge the count reaches zero.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= !load_i && (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

endmodule

// *** power_mode_controller.sv ***
// Power mode controller: mode sequencing, domain and clock gating, I/O latching.
`timescale 1ns/1ps
module power_mode_controller
  import pmc_pkg::*;
#(
  parameter int unsigned NUM_IO        = 16,
  parameter int unsigned WAKE_STBY_CYC = WAKE_STBY_CYCLES,
  parameter int unsigned WAKE_BOOT_CYC = WAKE_BOOT_CYCLES,
  parameter int unsigned RECHARGE_CYC  = RECHARGE_CYCLES
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Software mode requests from the main processor.
  input  wire logic              req_idle_i,
  input  wire logic              req_standby_i,
  input  wire logic              req_shutdown_i,
  // Wake sources.
  input  wire logic              irq_i,
  input  wire logic              pin_edge_i,
  input  wire logic              rtc_evt_i,
  input  wire logic              sensor_evt_i,
  input  wire logic              sensor_wake_en_i,
  input  wire logic              reset_pin_i,
  input  wire logic              brownout_i,
  // I/O pins.
  input  wire logic [NUM_IO-1:0] io_drive_i,
  input  wire logic [NUM_IO-1:0] io_in_i,
  input  wire logic [NUM_IO-1:0] sd_wake_sel_i,
  output logic      [NUM_IO-1:0] io_o,
  output logic                   io_latch_o,
  // Clock source selection.
  input  wire logic              fast_xtal_sel_i,
  input  wire logic              slow_xtal_sel_i,
  // Mode and status.
  output logic      [3:0]        mode_o,
  output logic      [1:0]        rst_cause_o,
  output logic                   locked_o,
  // Processor and peripheral control.
  output logic                   cpu_run_o,
  output logic                   cpu_resume_o,
  output logic                   cpu_clk_en_o,
  output logic                   mem_clk_en_o,
  output logic                   periph_clk_en_o,
  output logic                   periph_pwr_en_o,
  output logic                   sram_ret_o,
  // Domain power.
  output logic                   always_on_domain_en_o,
  output logic                   sensor_pwr_en_o,
  output logic                   brownout_detector_en_o,
  // Oscillators.
  output logic                   fast_crystal_osc_en_o,
  output logic                   fast_rc_osc_en_o,
  output logic                   doubler_en_o,
  output logic                   slow_crystal_osc_en_o,
  output logic                   slow_rc_osc_en_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pmc_state_e              state_q;      // Current mode.
  pmc_state_e              state_d;      // Next mode.
  pmc_state_e              target_q;     // Mode chosen by the last request.
  logic [TMR_W-1:0]        tmr_val;      // Count to load into the timer.
  logic                    tmr_load;     // Timer load strobe.
  logic                    tmr_done;     // Timer expiry pulse.
  logic                    boot_q;       // Current wake is a full reboot.
  logic                    brownout_trip_q;  // Brown-out seen in standby.
  logic [NUM_IO-1:0]       sd_ref_q;     // Pin levels on shutdown entry.
  logic                    sd_change;    // A shutdown wake pin moved.
  logic                    stby_wake;    // Any standby wake source.
  logic                    hold_io;      // Next cycle keeps the pins latched.
  logic [TMR_W-1:0]        rchg_q;       // Recharge period divider.
  logic                    rchg_tick;    // One-cycle recharge enable.
  logic                    req_any;      // Any software entry request.

  // Length of a timed step, adjusted so the mode changes exactly cyc edges later.
  function automatic logic [TMR_W-1:0] steps(input int unsigned cyc);
    steps = TMR_W'(cyc - 1);
  endfunction

  // ----------------------------------------------------------------
  // Wake qualification
  // ----------------------------------------------------------------
  // Standby wakes on a pin edge, a clock event or a selected sensor event.
  assign stby_wake = pin_edge_i || rtc_evt_i || (sensor_evt_i && sensor_wake_en_i);
  // Only pins picked as shutdown wake pins may end a shutdown.
  assign sd_change = |((io_in_i ^ sd_ref_q) & sd_wake_sel_i);
  assign req_any   = req_idle_i || req_standby_i || req_shutdown_i;
  assign hold_io   = (state_d == ST_STANDBY) || (state_d == ST_SHUTDOWN);

  // ----------------------------------------------------------------
  // Wake timer
  // ----------------------------------------------------------------
  // Times both the power-down sequence and each wake latency.
  wake_timer #(
    .WIDTH   (TMR_W)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (tmr_load),
    .count_i (tmr_val),
    .done_o  (tmr_done)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // The reset pin overrides every mode; other exits depend on the mode.
  always_comb begin
    state_d  = state_q;
    tmr_load = 1'b0;
    tmr_val  = '0;
    if (reset_pin_i) begin
      // The reset pin wakes from any mode, locked included; held reset stays held while it is asserted.
      state_d = ST_HELD;
    end else begin
      case (state_q)
        ST_ACTIVE: begin
          // Low-power entry starts only on a software request.
          if (req_any) begin
            state_d  = ST_PD;
            tmr_load = 1'b1;
            tmr_val  = steps(PD_CYCLES);
          end
        end
        ST_PD: begin
          // Domains drop only once the sequence has run out.
          if (tmr_done) begin
            state_d = target_q;
          end
        end
        ST_IDLE: begin
          // Any interrupt, pin edge or clock event ends idle.
          if (irq_i || pin_edge_i || rtc_evt_i) begin
            state_d  = ST_WAKE;
            tmr_load = 1'b1;
            tmr_val  = steps(WAKE_IDLE_CYCLES);
          end
        end
        ST_STANDBY: begin
          // Ordinary interrupts are ignored here.
          if (stby_wake) begin
            state_d  = ST_WAKE;
            tmr_load = 1'b1;
            tmr_val  = steps(WAKE_STBY_CYC);
          end
        end
        ST_SHUTDOWN: begin
          // A wake pin change restarts the chip as a reset would.
          if (sd_change) begin
            state_d  = ST_WAKE;
            tmr_load = 1'b1;
            tmr_val  = steps(WAKE_BOOT_CYC);
          end
        end
        ST_HELD: begin
          // Release of the reset pin boots the chip.
          state_d  = ST_WAKE;
          tmr_load = 1'b1;
          tmr_val  = steps(WAKE_BOOT_CYC);
        end
        ST_WAKE: begin
          // A brown-out caught in standby locks the chip instead.
          if (tmr_done) begin
            state_d = brownout_trip_q ? ST_LOCKED : ST_ACTIVE;
          end
        end
        default: begin
          // Locked stays until a reset pin or power-on reset.
          state_d = state_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Holds the current mode.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // Remembers which low-power mode was asked for; deepest request wins.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      target_q <= ST_IDLE;
    end else if (state_q == ST_ACTIVE && req_any) begin
      if (req_shutdown_i) begin
        target_q <= ST_SHUTDOWN;
      end else if (req_standby_i) begin
        target_q <= ST_STANDBY;
      end else begin
        target_q <= ST_IDLE;
      end
    end
  end

  // Marks wakes from shutdown or reset as reboots rather than resumes.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_q <= 1'b1;
    end else if (state_d == ST_WAKE && state_q != ST_WAKE) begin
      boot_q <= (state_q == ST_SHUTDOWN) || (state_q == ST_HELD);
    end
  end

  // ----------------------------------------------------------------
  // Brown-out handling
  // ----------------------------------------------------------------
  // Divider that opens the detector once per supply recharge.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rchg_q <= '0;
    end else if (state_q != ST_STANDBY || rchg_q == TMR_W'(RECHARGE_CYC - 1)) begin
      rchg_q <= '0;
    end else begin
      rchg_q <= rchg_q + 1'b1;
    end
  end
  assign rchg_tick = (state_q == ST_STANDBY) && (rchg_q == TMR_W'(RECHARGE_CYC - 1));

  // A trip taken in standby is kept until a reset clears it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      brownout_trip_q <= 1'b0;
    end else if (state_q == ST_STANDBY && brownout_detector_en_o && brownout_i) begin
      brownout_trip_q <= 1'b1;
    end else if (state_q == ST_HELD) begin
      brownout_trip_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset cause and pin latching
  // ----------------------------------------------------------------
  // Records why the chip last restarted.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_cause_o <= CAUSE_POR;
    end else if (state_d == ST_HELD) begin
      rst_cause_o <= CAUSE_PIN;
    end else if (state_q == ST_SHUTDOWN && state_d == ST_WAKE) begin
      rst_cause_o <= CAUSE_SDWAKE;
    end
  end

  // Captures the wake pin levels when shutdown is entered.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sd_ref_q <= '0;
    end else if (state_d == ST_SHUTDOWN && state_q != ST_SHUTDOWN) begin
      sd_ref_q <= io_in_i;
    end
  end

  // Pins follow their drivers except in standby and shutdown.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_o       <= '0;
      io_latch_o <= 1'b0;
    end else begin
      io_latch_o <= hold_io;
      if (!hold_io) begin
        io_o <= io_drive_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Domain and clock outputs
  // ----------------------------------------------------------------
  // Every control output is decoded from the next mode into a register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_o                 <= ST_ACTIVE;
      locked_o               <= 1'b0;
      cpu_run_o              <= 1'b1;
      cpu_resume_o           <= 1'b0;
      cpu_clk_en_o           <= 1'b1;
      mem_clk_en_o           <= 1'b1;
      periph_clk_en_o        <= 1'b1;
      periph_pwr_en_o        <= 1'b1;
      sram_ret_o             <= 1'b0;
      always_on_domain_en_o  <= 1'b1;
      sensor_pwr_en_o        <= 1'b1;
      brownout_detector_en_o <= 1'b1;
      fast_crystal_osc_en_o  <= 1'b0;
      fast_rc_osc_en_o       <= 1'b1;
      doubler_en_o           <= 1'b0;
      slow_crystal_osc_en_o  <= 1'b0;
      slow_rc_osc_en_o       <= 1'b1;
    end else begin
      mode_o          <= state_d;
      locked_o        <= (state_d == ST_LOCKED);
      // The processor and memory run only in active mode.
      cpu_run_o       <= (state_d == ST_ACTIVE);
      cpu_clk_en_o    <= (state_d == ST_ACTIVE);
      mem_clk_en_o    <= (state_d == ST_ACTIVE);
      cpu_resume_o    <= (state_d == ST_ACTIVE) && !boot_q;
      // Peripherals keep their clock through idle and the entry sequence.
      periph_clk_en_o <= (state_d == ST_ACTIVE) || (state_d == ST_IDLE)
                         || (state_d == ST_PD);
      periph_pwr_en_o <= (state_d != ST_STANDBY) && (state_d != ST_SHUTDOWN)
                         && (state_d != ST_HELD);
      // Retention holds registers and memory through standby.
      sram_ret_o      <= (state_d == ST_STANDBY);
      // Always-on logic and the sensor processor lose power only when off.
      always_on_domain_en_o <= (state_d != ST_SHUTDOWN) && (state_d != ST_HELD);
      sensor_pwr_en_o <= (state_d != ST_SHUTDOWN) && (state_d != ST_HELD);
      // The detector is duty cycled in standby and off when unpowered.
      if (state_d == ST_STANDBY) begin
        brownout_detector_en_o <= rchg_tick;
      end else begin
        brownout_detector_en_o <= (state_d != ST_SHUTDOWN) && (state_d != ST_HELD);
      end
      // The fast clock stops in standby and below.
      if ((state_d == ST_ACTIVE) || (state_d == ST_IDLE) || (state_d == ST_PD)
          || (state_d == ST_WAKE) || (state_d == ST_LOCKED)) begin
        fast_crystal_osc_en_o <= fast_xtal_sel_i;
        doubler_en_o          <= fast_xtal_sel_i;
        fast_rc_osc_en_o      <= !fast_xtal_sel_i;
      end else begin
        fast_crystal_osc_en_o <= 1'b0;
        doubler_en_o          <= 1'b0;
        fast_rc_osc_en_o      <= 1'b0;
      end
      // The slow clock keeps running everywhere but shutdown and held reset.
      if ((state_d == ST_SHUTDOWN) || (state_d == ST_HELD)) begin
        slow_crystal_osc_en_o <= 1'b0;
        slow_rc_osc_en_o      <= 1'b0;
      end else begin
        slow_crystal_osc_en_o <= slow_xtal_sel_i;
        slow_rc_osc_en_o      <= !slow_xtal_sel_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Entry sequence: four cycles of power-down, then the chosen mode.
  sequence s_entry;
    (state_q == ST_PD) [*4] ##1 (state_q == target_q);
  endsequence

  // Active mode keeps the processor and peripheral clocks running.
  AST_ACTIVE_RUN: assert property ((mode_o == ST_ACTIVE) |-> cpu_clk_en_o
    && periph_clk_en_o)
    else $error("active mode without processor clock");

  // Idle gates the core but not the peripherals.
  AST_IDLE_GATE: assert property ((mode_o == ST_IDLE) |->
    !cpu_clk_en_o && !mem_clk_en_o && periph_clk_en_o)
    else $error("idle clocks wrong");

  // An interrupt in idle runs the processor exactly 14 us later; a reset pin aborts the check.
  AST_IDLE_LATENCY: assert property (disable iff (rst_i || reset_pin_i)
    (state_q == ST_IDLE) && irq_i |-> ##[560:560] !cpu_run_o ##1 cpu_run_o)
    else $error("idle wake latency wrong");

  // A bare interrupt does not end standby.
  AST_STBY_DEAF: assert property ((state_q == ST_STANDBY) && !stby_wake
    && !reset_pin_i |=> (state_q == ST_STANDBY))
    else $error("standby left without a wake source");

  // Pins do not move while latched.
  AST_IO_HOLD: assert property (io_latch_o && $past(io_latch_o) |-> $stable(io_o))
    else $error("latched pin changed");

  // Shutdown removes the always-on and sensor domains, the slow clock and the fast RC oscillator, and latches the pins.
  AST_SD_OFF: assert property ((mode_o == ST_SHUTDOWN) |-> !always_on_domain_en_o
    && !sensor_pwr_en_o && !slow_rc_osc_en_o && !slow_crystal_osc_en_o
    && !fast_rc_osc_en_o && io_latch_o)
    else $error("shutdown left power on");

  // A shutdown wake pin change reboots and is recorded as such.
  AST_SD_WAKE: assert property ((state_q == ST_SHUTDOWN) && sd_change && !reset_pin_i
    |=> (state_q == ST_WAKE) && (rst_cause_o == CAUSE_SDWAKE) ##1 boot_q)
    else $error("shutdown wake not handled as reset");

  // The reset pin enters held reset from any mode.
  AST_PIN_RESET: assert property (reset_pin_i |=> (state_q == ST_HELD)
    && (rst_cause_o == CAUSE_PIN))
    else $error("reset pin ignored");

  // Standby stops the fast clock; the slow clock runs.
  AST_STBY_CLK: assert property ((mode_o == ST_STANDBY) |-> !fast_crystal_osc_en_o
    && !fast_rc_osc_en_o && (slow_rc_osc_en_o || slow_crystal_osc_en_o)
    && always_on_domain_en_o)
    else $error("standby clocks wrong");

  // Leaving active mode needs a request and runs the full sequence; a reset pin aborts it.
  AST_ENTRY: assert property (disable iff (rst_i || reset_pin_i)
    (state_q == ST_ACTIVE) && req_any |=> s_entry)
    else $error("entry sequence wrong");

endmodule

// *** tb.sv ***
// Self-checking testbench for the power mode controller.
`timescale 1ns/1ps
module tb;
  import pmc_pkg::*;
  // ----------------------------------------------------------------
  // Signals, with short standby and boot wake latencies so the run stays brief.
  // ----------------------------------------------------------------
  localparam int STB  = 20;  // Standby wake latency in cycles.
  localparam int BOOT = 30;  // Shutdown and held wake latency in cycles.
  logic       clk_i = 1'h0, rst_i = 1'h1, reset_pin_i = 1'h0;
  logic       req_idle_i = 1'h0, req_standby_i = 1'h0, req_shutdown_i = 1'h0;
  logic       irq_i = 1'h0, pin_edge_i = 1'h0, rtc_evt_i = 1'h0, sensor_evt_i = 1'h0;
  logic       sensor_wake_en_i = 1'h1, fast_xtal_sel_i = 1'h1, slow_xtal_sel_i = 1'h0;
  logic [3:0] io_drive_i = 4'h0, io_in_i = 4'h0, sd_wake_sel_i = 4'h2, io_o, mode_o;
  logic [1:0] rst_cause_o;
  logic       io_latch_o, cpu_run_o, cpu_resume_o, cpu_clk_en_o, periph_clk_en_o;
  logic       sram_ret_o, always_on_domain_en_o, fast_crystal_osc_en_o, slow_rc_osc_en_o;
  logic       brownout_i = 1'h0, locked_o, mem_clk_en_o, periph_pwr_en_o, sensor_pwr_en_o;
  logic       brownout_detector_en_o, fast_rc_osc_en_o, doubler_en_o, slow_crystal_osc_en_o;
  int         n_errors = 0, tests_run = 0;

  // The brown-out input is raised only by the lock scenario.
  power_mode_controller #(.NUM_IO(4), .WAKE_STBY_CYC(STB), .WAKE_BOOT_CYC(BOOT),
    .RECHARGE_CYC(8)) u_dut (
    .clk_i, .rst_i, .req_idle_i, .req_standby_i, .req_shutdown_i, .irq_i, .pin_edge_i,
    .rtc_evt_i, .sensor_evt_i, .sensor_wake_en_i, .reset_pin_i, .brownout_i,
    .io_drive_i, .io_in_i, .sd_wake_sel_i, .io_o, .io_latch_o, .fast_xtal_sel_i,
    .slow_xtal_sel_i, .mode_o, .rst_cause_o, .locked_o, .cpu_run_o, .cpu_resume_o,
    .cpu_clk_en_o, .mem_clk_en_o, .periph_clk_en_o, .periph_pwr_en_o, .sram_ret_o,
    .always_on_domain_en_o, .sensor_pwr_en_o, .brownout_detector_en_o,
    .fast_crystal_osc_en_o, .fast_rc_osc_en_o, .doubler_en_o,
    .slow_crystal_osc_en_o, .slow_rc_osc_en_o);

  // The 40 MHz clock toggles every half period.
  always #12.5 clk_i = ~clk_i;

  // Compares one observed value against its expectation.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Pulses a software request for one cycle and waits out the power-down.
  task automatic enter(input int unsigned which);
    @(posedge clk_i);
    {req_shutdown_i, req_standby_i, req_idle_i} <= 3'h1 << which;
    @(posedge clk_i);
    {req_shutdown_i, req_standby_i, req_idle_i} <= 3'h0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // Pulses wake sources, ordered irq, pin edge, clock event, sensor event.
  task automatic fire(input logic [3:0] src);
    @(posedge clk_i);
    {irq_i, pin_edge_i, rtc_evt_i, sensor_evt_i} <= src;
    @(posedge clk_i);
    {irq_i, pin_edge_i, rtc_evt_i, sensor_evt_i} <= 4'h0;
  endtask

  // Counts edges after the one that sampled the wake source, until the processor runs.
  task automatic wake_time(input int exp_n, input string what);
    int n;
    n = 0;
    while (mode_o !== ST_ACTIVE) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 50000) begin
        n_errors++;
        $display("Error at %0t: %s never woke", $time, what);
        give_verdict();
      end
    end
    chk(n, exp_n, what);
  endtask

  task automatic t_reset();
    @(posedge clk_i);
    #1;
    chk(mode_o, ST_ACTIVE, "reset mode");
    chk({cpu_run_o, cpu_clk_en_o, mem_clk_en_o, periph_clk_en_o, fast_crystal_osc_en_o,
         doubler_en_o, fast_rc_osc_en_o}, 7'h7E, "run");
    chk(rst_cause_o, CAUSE_POR, "cause");
    $display("test reset done");
  endtask

  task automatic t_idle();
    enter(0);
    chk(mode_o, ST_IDLE, "idle entry");
    chk({cpu_clk_en_o, mem_clk_en_o, periph_clk_en_o}, 3'h1, "idle clocks");
    fire(4'h8);
    wake_time(560, "idle wake");
    chk(cpu_resume_o, 1'h1, "idle resume");
    $display("test idle done");
  endtask

  task automatic t_standby();
    @(posedge clk_i);
    io_drive_i <= 4'h5;
    enter(1);
    chk(mode_o, ST_STANDBY, "stby entry");
    chk({always_on_domain_en_o, periph_clk_en_o, sram_ret_o, periph_pwr_en_o,
         brownout_detector_en_o}, 5'h14, "stby power");
    chk({fast_crystal_osc_en_o, slow_rc_osc_en_o}, 2'h1, "stby clocks");
    @(posedge clk_i);
    io_drive_i <= 4'hA;
    fire(4'h8);
    repeat (3) @(posedge clk_i);
    #1;
    chk(mode_o, ST_STANDBY, "irq ignored");
    chk({io_latch_o, io_o}, 5'h15, "pins held");
    fire(4'h1);
    wake_time(STB, "stby wake");
    chk({cpu_resume_o, io_o}, 5'h1A, "resume");
    $display("test standby done");
  endtask

  task automatic t_shutdown();
    enter(2);
    chk(mode_o, ST_SHUTDOWN, "sd entry");
    chk({always_on_domain_en_o, sensor_pwr_en_o, fast_crystal_osc_en_o, slow_rc_osc_en_o,
         slow_crystal_osc_en_o, io_latch_o}, 6'h01, "sd off");
    @(posedge clk_i);
    io_in_i <= 4'h1;
    fire(4'h2);
    repeat (3) @(posedge clk_i);
    #1;
    chk(mode_o, ST_SHUTDOWN, "sd ignores");
    @(posedge clk_i);
    io_in_i <= 4'h3;
    @(posedge clk_i);
    wake_time(BOOT, "sd wake");
    chk({cpu_resume_o, rst_cause_o}, {1'h0, CAUSE_SDWAKE}, "sd cause");
    $display("test shutdown done");
  endtask

  task automatic t_held();
    @(posedge clk_i);
    reset_pin_i <= 1'h1;
    fire(4'h6);
    repeat (2) @(posedge clk_i);
    #1;
    chk({mode_o, rst_cause_o}, {ST_HELD, CAUSE_PIN}, "held");
    chk({always_on_domain_en_o, sensor_pwr_en_o}, 2'h0, "held domains");
    @(posedge clk_i);
    reset_pin_i <= 1'h0;
    @(posedge clk_i);
    wake_time(BOOT, "held wake");
    chk(cpu_run_o, 1'h1, "run");
    $display("test held done");
  endtask

  // A brown-out in standby locks the chip after wake; the reset pin frees it.
  task automatic t_lock();
    @(posedge clk_i);
    brownout_i <= 1'h1;
    enter(1);
    @(posedge clk_i);
    sensor_wake_en_i <= 1'h0;
    fire(4'h1);
    repeat (8) @(posedge clk_i);
    #1;
    chk(mode_o, ST_STANDBY, "sensor masked");
    fire(4'h4);
    repeat (STB) @(posedge clk_i);
    #1;
    chk({locked_o, cpu_run_o, mode_o}, {2'h2, ST_LOCKED}, "locked");
    @(posedge clk_i);
    reset_pin_i <= 1'h1;
    brownout_i  <= 1'h0;
    @(posedge clk_i);
    reset_pin_i <= 1'h0;
    @(posedge clk_i);
    wake_time(BOOT, "unlock");
    chk({locked_o, cpu_resume_o}, 2'h0, "unlocked");
    $display("test lock done");
  endtask

  // Holds reset for four cycles, then runs every scenario in turn.
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_idle();
    t_standby();
    t_shutdown();
    t_held();
    t_lock();
    give_verdict();
  end
endmodule
